// ### hw/mcts_core.sv
// Command interpreter for a servo actuator: decodes host frames, replies, holds motor state.
// Assumes one request is offered per valid pulse and sensor inputs are live measurements.
//
// Summary of operation
// - Command 0x9D reads temperature and three phase currents, reply echoes the command.
// - Phase reply holds currents A, B, C in bytes 2-3, 4-5, 6-7, 0.01 A.
// - Command 0x80 turns output off, clears running and leaves closed loop.
// - Command 0x81 halts speed but keeps closed loop and running state.
// - Shutdown and stop replies copy the request data bytes exactly.
// - Torque command 0xA1 changes setpoint and motor state only while no motor fault is present; it replies either way.
// - A torque command decoded while no motor fault is present makes its setpoint the target current.
// - Torque reply carries measured torque current in bytes 2 low, 3 high.
// - Torque reply carries shaft speed in bytes 4 low, 5 high.
// - Torque reply carries shaft angle in bytes 6 low, 7 high.
// - Multi-byte fields go low byte first, signed in two's complement.
// - Byte 1 of sensor replies holds signed temperature in whole degrees.
`timescale 1ns/10ps

module mcts_core
	import mcts_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    req_valid,
	input  wire mcts_pkg::mcts_msg_type  req_msg,
	input  wire mcts_pkg::mcts_sense_type sense,
	input  wire logic                    motor_fault,
	output logic                         rsp_valid,
	output mcts_pkg::mcts_msg_type       rsp_msg,
	output logic                         motor_output_en,
	output logic                         motor_running,
	output mcts_pkg::mcts_mode_type      control_mode,
	output logic                         speed_halt,
	output logic signed [15:0]           torque_current_setpoint
);
	import mcts_pkg::*;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic mcts_frame_type sensor_reply(
		input logic [7:0]  cmd,
		input logic [7:0]  temp,
		input logic [15:0] w0,
		input logic [15:0] w1,
		input logic [15:0] w2
	);
		mcts_frame_type f;
		f = '0;
		f[POS_CMD]       = cmd;
		f[POS_TEMP]      = temp;
		f[POS_WORD0]     = w0[7:0];
		f[POS_WORD0 + 1] = w0[15:8];
		f[POS_WORD1]     = w1[7:0];
		f[POS_WORD1 + 1] = w1[15:8];
		f[POS_WORD2]     = w2[7:0];
		f[POS_WORD2 + 1] = w2[15:8];
		return f;
	endfunction : sensor_reply

	// ********************************************************
	// State
	// ********************************************************
	logic                rsp_valid_reg;
	logic                rsp_valid_next;
	mcts_msg_type        rsp_msg_reg;
	mcts_msg_type        rsp_msg_next;
	logic                out_en_reg;
	logic                out_en_next;
	logic                running_reg;
	logic                running_next;
	mcts_mode_type       mode_reg;
	mcts_mode_type       mode_next;
	logic                halt_reg;
	logic                halt_next;
	logic signed [15:0]  setpoint_reg;
	logic signed [15:0]  setpoint_next;
	logic                addressed;
	logic [7:0]          cmd;

	// Frames for other motors are ignored so a shared bus stays quiet
	assign addressed = req_valid && (req_msg.id == CAN_REQ_ID);
	assign cmd       = req_msg.data[POS_CMD];

	always_comb
	begin
		rsp_valid_next = 1'b0;
		rsp_msg_next   = rsp_msg_reg;
		out_en_next    = out_en_reg;
		running_next   = running_reg;
		mode_next      = mode_reg;
		halt_next      = halt_reg;
		setpoint_next  = setpoint_reg;
		if (addressed)
		begin
			case (cmd)
				CMD_PHASE_READ:
				begin
					rsp_valid_next = 1'b1;
					rsp_msg_next.data = sensor_reply(cmd, sense.temperature,
						sense.phase_a_current, sense.phase_b_current,
						sense.phase_c_current);
				end
				CMD_SHUTDOWN:
				begin
					rsp_valid_next    = 1'b1;
					rsp_msg_next.data = req_msg.data;
					out_en_next       = 1'b0;
					running_next      = 1'b0;
					mode_next         = MCTS_MODE_OFF;
					halt_next         = 1'b0;
					setpoint_next     = RST_SETPOINT;
				end
				CMD_STOP:
				begin
					rsp_valid_next    = 1'b1;
					rsp_msg_next.data = req_msg.data;
					halt_next         = 1'b1;
				end
				CMD_TORQUE:
				begin
					// A faulted motor still answers so the host sees its state
					rsp_valid_next = 1'b1;
					rsp_msg_next.data = sensor_reply(cmd, sense.temperature,
						sense.measured_torque_current,
						sense.shaft_speed,
						sense.shaft_angle);
					if (!motor_fault)
					begin
						setpoint_next = {req_msg.data[POS_SETPOINT + 1],
							req_msg.data[POS_SETPOINT]};
						mode_next     = MCTS_MODE_TORQUE;
						out_en_next   = 1'b1;
						running_next  = 1'b1;
						halt_next     = 1'b0;
					end
				end
				default:
				begin
					rsp_valid_next = 1'b0;
				end
			endcase
			// Unknown opcodes leave the held reply untouched, identifier included
			if (rsp_valid_next)
				rsp_msg_next.id = CAN_RSP_ID;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rsp_valid_reg <= 1'b0;
			rsp_msg_reg   <= '0;
			out_en_reg    <= 1'b0;
			running_reg   <= 1'b0;
			mode_reg      <= MCTS_MODE_OFF;
			halt_reg      <= 1'b0;
			setpoint_reg  <= RST_SETPOINT;
		end
		else
		begin
			rsp_valid_reg <= rsp_valid_next;
			rsp_msg_reg   <= rsp_msg_next;
			out_en_reg    <= out_en_next;
			running_reg   <= running_next;
			mode_reg      <= mode_next;
			halt_reg      <= halt_next;
			setpoint_reg  <= setpoint_next;
		end
	end

	assign rsp_valid               = rsp_valid_reg;
	assign rsp_msg                 = rsp_msg_reg;
	assign motor_output_en         = out_en_reg;
	assign motor_running           = running_reg;
	assign control_mode            = mode_reg;
	assign speed_halt              = halt_reg;
	assign torque_current_setpoint = setpoint_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_req(logic [7:0] c);
		req_valid && req_msg.id == CAN_REQ_ID && req_msg.data[0] == c;
	endsequence

	sequence s_torque(logic f);
		req_valid && req_msg.id == CAN_REQ_ID && req_msg.data[0] == CMD_TORQUE
			&& motor_fault == f;
	endsequence

	a_phase_reply: assert property (s_req(CMD_PHASE_READ) |=> rsp_valid
		&& rsp_msg.data[0] == 8'h9d && rsp_msg.id == 11'h241)
		else $error("phase read reply missing or wrong");
	a_phase_words: assert property (s_req(CMD_PHASE_READ) |=>
		{rsp_msg.data[3], rsp_msg.data[2]} == $past(sense.phase_a_current)
		&& {rsp_msg.data[5], rsp_msg.data[4]} == $past(sense.phase_b_current)
		&& {rsp_msg.data[7], rsp_msg.data[6]} == $past(sense.phase_c_current))
		else $error("phase currents misplaced");
	a_shutdown_state: assert property (s_req(CMD_SHUTDOWN) |=>
		!motor_output_en && !motor_running && control_mode == MCTS_MODE_OFF)
		else $error("shutdown left motor active");
	a_stop_keeps: assert property (s_req(CMD_STOP) |=> speed_halt
		&& $stable(control_mode) && $stable(motor_running))
		else $error("stop changed loop state");
	a_echo_reply: assert property ((s_req(CMD_SHUTDOWN) or s_req(CMD_STOP))
		|=> rsp_valid && rsp_msg.data == $past(req_msg.data))
		else $error("echo reply differs from request");
	a_fault_block: assert property (s_torque(1'b1)
		|=> $stable(torque_current_setpoint) && $stable(control_mode))
		else $error("torque command acted during fault");
	a_torque_set: assert property (s_torque(1'b0) |=>
		torque_current_setpoint == $past({req_msg.data[5], req_msg.data[4]})
		&& control_mode == MCTS_MODE_TORQUE && motor_output_en && !speed_halt)
		else $error("torque setpoint not applied");
	a_torque_reply: assert property (s_req(CMD_TORQUE) |=> rsp_valid
		&& {rsp_msg.data[3], rsp_msg.data[2]} == $past(sense.measured_torque_current)
		&& {rsp_msg.data[5], rsp_msg.data[4]} == $past(sense.shaft_speed)
		&& {rsp_msg.data[7], rsp_msg.data[6]} == $past(sense.shaft_angle))
		else $error("torque reply fields wrong");
	a_temp_byte: assert property ((s_req(CMD_TORQUE) or s_req(CMD_PHASE_READ))
		|=> rsp_msg.data[1] == $past(sense.temperature))
		else $error("temperature byte wrong");
	a_no_stray: assert property (!(req_valid && req_msg.id == CAN_REQ_ID)
		|=> !rsp_valid ##1 1'b1)
		else $error("reply without addressed request");

endmodule : mcts_core

// ### hw/mcts_pkg.sv
// Package for the servo command interpreter: opcodes, frame layout, link codes.
// Assumes the link layer delivers whole 8-byte payloads with their identifier.
package mcts_pkg;

	// ********************************************************
	// Frame carriers
	// ********************************************************
	typedef logic [7:0]       mcts_byte_type;
	typedef mcts_byte_type [7:0] mcts_frame_type;

	typedef struct packed {
		logic [10:0]    id;
		mcts_frame_type data;
	} mcts_msg_type;

	typedef struct packed {
		logic signed [7:0]  temperature;
		logic signed [15:0] phase_a_current;
		logic signed [15:0] phase_b_current;
		logic signed [15:0] phase_c_current;
		logic signed [15:0] measured_torque_current;
		logic signed [15:0] shaft_speed;
		logic signed [15:0] shaft_angle;
	} mcts_sense_type;

	typedef enum logic [1:0] {
		MCTS_MODE_OFF,
		MCTS_MODE_TORQUE
	} mcts_mode_type;

	// ********************************************************
	// Command codes and field positions
	// ********************************************************
	localparam logic [7:0]  CMD_PHASE_READ   = 8'h9d;
	localparam logic [7:0]  CMD_SHUTDOWN     = 8'h80;
	localparam logic [7:0]  CMD_STOP         = 8'h81;
	localparam logic [7:0]  CMD_TORQUE       = 8'ha1;
	localparam int          POS_CMD          = 0;
	localparam int          POS_TEMP         = 1;
	localparam int          POS_WORD0        = 2;
	localparam int          POS_WORD1        = 4;
	localparam int          POS_WORD2        = 6;
	localparam int          POS_SETPOINT     = 4;

	// ********************************************************
	// Link identifiers and serial framing
	// ********************************************************
	localparam logic [10:0] CAN_REQ_ID       = 11'h141;
	localparam logic [10:0] CAN_RSP_ID       = 11'h241;
	localparam logic [7:0]  SERIAL_HEADER    = 8'h3e;
	localparam logic [7:0]  SERIAL_LENGTH    = 8'h08;
	localparam logic [15:0] RST_SETPOINT     = 16'h0000;
	localparam logic [10:0] RST_ID           = 11'h000;

endpackage : mcts_pkg

// ### verif/mcts_host.sv
// Host controller model: offers one request frame per call of send.
// Assumes a single bench process calls send, with a free-running clk.
`timescale 1ns/10ps

module mcts_host
	import mcts_pkg::*;
(
	input  wire logic              clk,
	output logic                   req_valid,
	output mcts_pkg::mcts_msg_type req_msg
);
	initial
	begin
		req_valid = 1'b0;
		req_msg   = '0;
	end

	// Request stands one cycle; afterwards the bus shows inverted bits so stale data cannot match
	task automatic send(input logic [10:0] id, input mcts_frame_type data);
		@(posedge clk);
		#1;
		req_msg.id   = id;
		req_msg.data = data;
		req_valid    = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		req_msg   = ~req_msg;
	endtask : send
endmodule : mcts_host

// ### verif/tb_mcts_core.sv
// Self-checking bench for the servo command interpreter.
// Assumes mcts_pkg and mcts_core are compiled first; frame literals put byte 0 lowest.
`timescale 1ns/10ps

module tb_mcts_core;
	import mcts_pkg::*;
	logic                    clk;
	logic                    rst_b;
	logic                    req_valid;
	mcts_msg_type            req_msg;
	mcts_sense_type          sense;
	logic                    motor_fault;
	logic                    rsp_valid;
	mcts_msg_type            rsp_msg;
	logic                    motor_output_en;
	logic                    motor_running;
	mcts_mode_type           control_mode;
	logic                    speed_halt;
	logic signed [15:0]      torque_current_setpoint;
	int                      fails;
	int                      comparisons;

	mcts_host host (.clk(clk), .req_valid(req_valid), .req_msg(req_msg));
	mcts_core dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_msg(req_msg),
		.sense(sense), .motor_fault(motor_fault), .rsp_valid(rsp_valid), .rsp_msg(rsp_msg),
		.motor_output_en(motor_output_en), .motor_running(motor_running),
		.control_mode(control_mode), .speed_halt(speed_halt),
		.torque_current_setpoint(torque_current_setpoint));

	always #12.5 clk = ~clk;

	// ********************************************************
	// Shared tasks
	// ********************************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Packed as output enable, running, mode, halt
	function automatic logic [63:0] state();
		return 64'({motor_output_en, motor_running, control_mode, speed_halt});
	endfunction : state

	task automatic xact(input logic [10:0] id, input mcts_frame_type d, input logic rep);
		host.send(id, d);
		check(64'(rsp_valid), 64'(rep));
		if (rep)
			check(64'(rsp_msg.id), 64'h241);
		@(posedge clk);
		#1;
		check(64'(rsp_valid), 64'h0);
	endtask : xact

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic t_phase();
		sense.phase_a_current = 16'sh0bc2;
		sense.phase_b_current = 16'shfa10;
		sense.phase_c_current = 16'shf9c0;
		xact(CAN_REQ_ID, 64'h9d, 1'b1);
		check(rsp_msg.data, 64'hf9c0fa100bc2329d);
		$display("test phase read done");
	endtask : t_phase

	task automatic t_torque();
		xact(CAN_REQ_ID, 64'h0000ff9c000000a1, 1'b1);
		check(rsp_msg.data, 64'hffd3fe0cff9c32a1);
		check({48'h0, torque_current_setpoint}, 64'hff9c);
		check(state(), 64'h1a);
		$display("test torque done");
	endtask : t_torque

	task automatic t_stop();
		xact(CAN_REQ_ID, 64'h81, 1'b1);
		check(rsp_msg.data, 64'h81);
		check(state(), 64'h1b);
		$display("test stop done");
	endtask : t_stop

	task automatic t_fault();
		motor_fault = 1'b1;
		sense.measured_torque_current = 16'sh0064;
		sense.shaft_speed = 16'sh01f4;
		sense.shaft_angle = 16'sh002d;
		xact(CAN_REQ_ID, 64'h00000064000000a1, 1'b1);
		// Fresh measurements tell a real faulted reply from the stale torque reply
		check(rsp_msg.data, 64'h002d01f4006432a1);
		check({48'h0, torque_current_setpoint}, 64'hff9c);
		check(state(), 64'h1b);
		motor_fault = 1'b0;
		$display("test fault done");
	endtask : t_fault

	task automatic t_shut();
		xact(CAN_REQ_ID, 64'h80, 1'b1);
		check(rsp_msg.data, 64'h80);
		check(state(), 64'h0);
		check({48'h0, torque_current_setpoint}, 64'h0);
		$display("test shutdown done");
	endtask : t_shut

	// Wrong identifier and unknown opcode must leave the setpoint from the last good frame
	task automatic t_refuse();
		xact(CAN_REQ_ID, 64'h00000064000000a1, 1'b1);
		xact(11'h142, 64'h0000ff9c000000a1, 1'b0);
		xact(CAN_REQ_ID, 64'h0000ff9c000000a2, 1'b0);
		check({48'h0, torque_current_setpoint}, 64'h64);
		check(state(), 64'h1a);
		$display("test refuse done");
	endtask : t_refuse

	initial
	begin
		#50000;
		fails++;
		conclude();
	end

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		motor_fault = 1'b0;
		fails = 0;
		comparisons = 0;
		sense = '0;
		sense.temperature = 8'sh32;
		sense.measured_torque_current = 16'shff9c;
		sense.shaft_speed = 16'shfe0c;
		sense.shaft_angle = 16'shffd3;
		repeat (2) @(posedge clk);
		#1;
		rst_b = 1'b1;
		check(state(), 64'h0);
		t_phase();
		t_torque();
		t_stop();
		t_fault();
		t_shut();
		t_refuse();
		conclude();
	end
endmodule : tb_mcts_core
